// File: inc/fpr_pkg.sv
`default_nettype none

package fpr_pkg;

    // processor bus and match array geometry
    localparam int ADDR_W = 16;
    localparam int MATCH_W = 14;
    localparam int MATCH_LSB = 2;
    localparam int TERMS = 48;
    localparam int TERM_IDX_W = 6;
    localparam int OR_W = 8;

    // fields of the eight array outputs
    localparam int FLD_XLT_LSB = 0;
    localparam int FLD_XLT_W = 6;
    localparam int FLD_BLOCK = 6;
    localparam int FLD_CORR = 7;

    // main rom decoder
    localparam int DEC_LSB = 11;
    localparam int DEC_W = 4;
    localparam int DEC_OUTS = 16;
    localparam int DEC_EN_BIT = 15;
    localparam int DEC_SYS_FIRST = 4;
    localparam int SYS_ROMS = 12;
    localparam int DEC_PATCH_REGION = 0;

    // patch prom addressing
    localparam int PATCH_AW = 11;
    localparam int PATCH_XLT_LSB = 3;
    localparam int PATCH_SIZE_BIT = 2;

    // bank rom window
    localparam logic [ADDR_W-1:0] BANK_BASE = 16'h6000;
    localparam int BANK_AW = 11;

    // reset contents: both senses connected, so no term can fire
    localparam logic [MATCH_W-1:0] MASK_RESET = 14'h3fff;
    localparam logic [OR_W-1:0] OR_RESET = 8'h00;

    // one programming write into the match array
    typedef struct packed {
        logic [TERM_IDX_W-1:0] term;
        logic [MATCH_W-1:0] trueMask;
        logic [MATCH_W-1:0] compMask;
        logic [OR_W-1:0] orMask;
    } fpr_prog_s;

    // registered selects towards the rom sockets
    typedef struct packed {
        logic [SYS_ROMS-1:0] systemRomEnableN;
        logic [DEC_OUTS-1:0] decodeN;
        logic bankRomEnableN;
        logic patchRomEnableN;
        logic correctN;
        logic [PATCH_AW-1:0] patchAddr;
        logic [BANK_AW-1:0] bankAddr;
    } fpr_sel_s;

endpackage

`default_nettype wire

// File: core/fpr_match_array.sv
`timescale 1ns/1ps
`default_nettype none

// programmable and/or plane: 48 product terms over 14 inputs, eight sums
module fpr_match_array
(
    input wire logic clk,
    input wire logic rst,
    input wire logic progWrite,
    input wire fpr_pkg::fpr_prog_s prog,
    input wire logic [fpr_pkg::MATCH_W-1:0] matchIn,
    output logic [fpr_pkg::OR_W-1:0] orOut,
    output logic [fpr_pkg::TERMS-1:0] termHit
);

    logic [fpr_pkg::MATCH_W-1:0] trueMask [fpr_pkg::TERMS];
    logic [fpr_pkg::MATCH_W-1:0] compMask [fpr_pkg::TERMS];
    logic [fpr_pkg::OR_W-1:0] orMask [fpr_pkg::TERMS];
    logic [fpr_pkg::OR_W-1:0] contrib [fpr_pkg::TERMS];

    // plane storage; a write to an index past the last term is dropped
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < fpr_pkg::TERMS; i++)
            begin
                trueMask[i] <= fpr_pkg::MASK_RESET;
                compMask[i] <= fpr_pkg::MASK_RESET;
                orMask[i] <= fpr_pkg::OR_RESET;
            end
        end
        else if (progWrite && (32'(prog.term) < fpr_pkg::TERMS))
        begin
            trueMask[prog.term] <= prog.trueMask;
            compMask[prog.term] <= prog.compMask;
            orMask[prog.term] <= prog.orMask;
        end
    end

    // each term fails on any connected sense that disagrees with its input
    generate
        for (genvar t = 0; t < fpr_pkg::TERMS; t++)
        begin : g_term
            assign termHit[t] = ~|((trueMask[t] & ~matchIn) | (compMask[t] & matchIn));
            assign contrib[t] = termHit[t] ? orMask[t] : '0;
        end
    endgenerate

    // or plane: every output may collect any of the 48 terms
    always_comb
    begin
        orOut = '0;
        for (int i = 0; i < fpr_pkg::TERMS; i++)
        begin
            orOut = orOut | contrib[i];
        end
    end

endmodule
`default_nettype wire

// File: core/fpr_remap.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - patched address suppresses system rom, enables patch
// - 48 terms, 14 inputs either sense, 8 outputs
// - match inputs are address bits 2 to 15
// - six array outputs form patch address 3-8
// - active-low correction disables system and bank rom
// - selector feeds prom from array or raw bus
// - correction line steers selector to translated address
// - patch prom enabled by correction or region decode
// - prom bit 2 is bus bit 2 xor size
// - decoder maps bits 11-14, only with bit 15
// - spare decoder outputs select patch region, buffers
// - bank rom answers 2 KB window at 6000
// - decoder second enable drops only during correction
module fpr_remap
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [fpr_pkg::ADDR_W-1:0] addrBus,
    input wire logic bankRomSelect,
    input wire logic progWrite,
    input wire fpr_pkg::fpr_prog_s prog,
    output fpr_pkg::fpr_sel_s sel,
    output logic progAck,
    output logic anyTermProgrammed
);

    logic [fpr_pkg::MATCH_W-1:0] matchIn;
    logic [fpr_pkg::OR_W-1:0] arrayOut;
    logic [fpr_pkg::TERMS-1:0] termHit;
    logic correctActive;
    logic blockSizeSelect;
    logic [fpr_pkg::FLD_XLT_W-1:0] xltAddr;
    logic decoderEnable;
    logic [fpr_pkg::DEC_W-1:0] decIndex;
    logic [fpr_pkg::DEC_OUTS-1:0] next_decodeN;
    logic patchRegionSelect;
    logic bankWindowHit;
    logic [fpr_pkg::PATCH_AW-1:0] next_patchAddr;
    fpr_pkg::fpr_sel_s next_sel;
    logic next_progAck;
    logic next_anyTermProgrammed;
    logic anyHit;
    logic [fpr_pkg::PATCH_AW-1:0] rawPatchAddr;
    logic [fpr_pkg::PATCH_AW-1:0] xltPatchAddr;
    logic next_correctN;
    logic next_bankRomEnableN;
    logic next_patchRomEnableN;
    logic termInRange;

    // the bus is driven by logic on this clock, so it is read without
    // synchronisers; one register stage keeps every select inside a cycle
    assign matchIn = addrBus[fpr_pkg::MATCH_LSB +: fpr_pkg::MATCH_W];

    fpr_match_array u_array
    (
        .clk(clk),
        .rst(rst),
        .progWrite(progWrite),
        .prog(prog),
        .matchIn(matchIn),
        .orOut(arrayOut),
        .termHit(termHit)
    );

    // hit summary; the fields only count while a programmed term fires
    assign anyHit = |termHit;

    // array output fields; with no term hit all of them read zero
    always_comb
    begin
        correctActive = anyHit && arrayOut[fpr_pkg::FLD_CORR];
        blockSizeSelect = anyHit && arrayOut[fpr_pkg::FLD_BLOCK];
        xltAddr = '0;
        if (anyHit)
        begin
            xltAddr = arrayOut[fpr_pkg::FLD_XLT_LSB +: fpr_pkg::FLD_XLT_W];
        end
    end

    // main decoder: enable one is bit 15, enable two is the correction line
    always_comb
    begin
        decIndex = addrBus[fpr_pkg::DEC_LSB +: fpr_pkg::DEC_W];
        decoderEnable = addrBus[fpr_pkg::DEC_EN_BIT] && !correctActive;
    end

    // one active-low line per decoder output; at most one is low at a time
    generate
        for (genvar y = 0; y < fpr_pkg::DEC_OUTS; y++)
        begin : g_dec
            assign next_decodeN[y] = !(decoderEnable && (32'(decIndex) == y));
        end
    endgenerate

    // the spare output y0 opens the patch prom region
    assign patchRegionSelect = !next_decodeN[fpr_pkg::DEC_PATCH_REGION];

    // bank window check guards against a stray select outside the window
    always_comb
    begin
        bankWindowHit = (addrBus[fpr_pkg::ADDR_W-1:fpr_pkg::BANK_AW]
            == fpr_pkg::BANK_BASE[fpr_pkg::ADDR_W-1:fpr_pkg::BANK_AW]);
    end

    // raw path: the bus itself, which lets a jump reach upper prom space
    always_comb
    begin
        rawPatchAddr = addrBus[fpr_pkg::PATCH_AW-1:0];
    end

    // translated path: array bits above the block, bus bits inside it;
    // the top two prom bits stay low, so in-place patches use lower space
    always_comb
    begin
        xltPatchAddr = '0;
        xltPatchAddr[fpr_pkg::PATCH_SIZE_BIT-1:0] = addrBus[fpr_pkg::PATCH_SIZE_BIT-1:0];
        xltPatchAddr[fpr_pkg::PATCH_XLT_LSB +: fpr_pkg::FLD_XLT_W] = xltAddr;
    end

    // selector steered by the correction line; bit 2 is flipped on either
    // path, and without a hit the size output is low so bus bit 2 passes
    always_comb
    begin
        next_patchAddr = rawPatchAddr;
        if (correctActive)
        begin
            next_patchAddr = xltPatchAddr;
        end
        next_patchAddr[fpr_pkg::PATCH_SIZE_BIT] =
            addrBus[fpr_pkg::PATCH_SIZE_BIT] ^ blockSizeSelect;
    end

    // correction line as seen by decoder, bank rom and selector; active low
    always_comb
    begin
        next_correctN = !correctActive;
    end

    // bank rom: its own select inside its window, silenced by a correction
    always_comb
    begin
        next_bankRomEnableN = 1'b1;
        if (bankRomSelect && bankWindowHit && !correctActive)
        begin
            next_bankRomEnableN = 1'b0;
        end
    end

    // patch prom: the correction or the spare decoder output opens it
    always_comb
    begin
        next_patchRomEnableN = !(correctActive || patchRegionSelect);
    end

    // gather the selects; the system roms hang on decoder outputs 4 to 15
    always_comb
    begin
        next_sel.decodeN = next_decodeN;
        next_sel.systemRomEnableN =
            next_decodeN[fpr_pkg::DEC_SYS_FIRST +: fpr_pkg::SYS_ROMS];
        next_sel.correctN = next_correctN;
        next_sel.bankRomEnableN = next_bankRomEnableN;
        next_sel.patchRomEnableN = next_patchRomEnableN;
        next_sel.patchAddr = next_patchAddr;
        next_sel.bankAddr = addrBus[fpr_pkg::BANK_AW-1:0];
    end

    // a term index past the last product term is dropped without an answer
    always_comb
    begin
        termInRange = 32'(prog.term) < fpr_pkg::TERMS;
    end

    // programming answer and a summary flag for field service; the flag
    // only ever sets, so erasing a term later does not clear it
    always_comb
    begin
        next_progAck = progWrite && termInRange;
        next_anyTermProgrammed = anyTermProgrammed;
        if (next_progAck && (prog.orMask != fpr_pkg::OR_RESET))
        begin
            next_anyTermProgrammed = 1'b1;
        end
    end

    // select register; every select lags its address by exactly one edge,
    // which is the single bus-cycle settle the processor allows
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sel.systemRomEnableN <= '1;
            sel.decodeN <= '1;
            sel.bankRomEnableN <= 1'b1;
            sel.patchRomEnableN <= 1'b1;
            sel.correctN <= 1'b1;
            sel.patchAddr <= '0;
            sel.bankAddr <= '0;
        end
        else
        begin
            sel <= next_sel;
        end
    end

    // programming register group
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            progAck <= 1'b0;
            anyTermProgrammed <= 1'b0;
        end
        else
        begin
            progAck <= next_progAck;
            anyTermProgrammed <= next_anyTermProgrammed;
        end
    end

endmodule
`default_nettype wire

// File: tb/fpr_remap_properties.sv
`timescale 1ns/1ps
`default_nettype none

// watches the remap ports; every select lags its address by one edge
module fpr_remap_properties
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [fpr_pkg::ADDR_W-1:0] addrBus,
    input wire logic bankRomSelect,
    input wire logic progWrite,
    input wire fpr_pkg::fpr_prog_s prog,
    input wire fpr_pkg::fpr_sel_s sel,
    input wire logic progAck,
    input wire logic anyTermProgrammed
);
    logic inWin;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // bank window hit, kept as one signal so $past sees a plain net
    assign inWin = bankRomSelect && addrBus[15:11] == 5'h0c;

    // a correction must leave only the patch prom on the data bus
    corr_blocks_rom_a: assert property (!sel.correctN |-> &sel.decodeN &&
        sel.bankRomEnableN && !sel.patchRomEnableN) else $error("rom left on in correction");
    dec_gate_a: assert property (!addrBus[15] |=> &sel.decodeN)
        else $error("decoder on below 8000");
    dec_pick_a: assert property (addrBus[15] |=> !sel.correctN ||
        sel.decodeN == ~(16'h0001 << $past(addrBus[14:11]))) else $error("wrong decoder line");
    bank_win_a: assert property (1'b1 |=>
        sel.bankRomEnableN == !(sel.correctN && $past(inWin))) else $error("bank select wrong");
    raw_path_a: assert property (sel.correctN && !$past(rst) |->
        sel.patchAddr == 11'($past(addrBus))) else $error("raw patch address wrong");
    xlt_shape_a: assert property (!sel.correctN |-> sel.patchAddr[10:9] == 2'b00 &&
        sel.patchAddr[1:0] == 2'($past(addrBus))) else $error("translated address wrong");
    patch_en_a: assert property (sel.correctN |->
        sel.patchRomEnableN == sel.decodeN[0]) else $error("patch enable wrong");
    unprog_idle_a: assert property (!anyTermProgrammed |-> sel.correctN)
        else $error("correction with empty array");

    cover property (!sel.correctN);
    cover property (!sel.bankRomEnableN);
    cover property (!sel.correctN && $past(inWin));
    cover property (progWrite && prog.orMask != 8'h00 ##1 progAck);
endmodule

bind fpr_remap fpr_remap_properties chk_i (.clk(clk), .rst(rst), .addrBus(addrBus),
    .bankRomSelect(bankRomSelect), .progWrite(progWrite), .prog(prog), .sel(sel),
    .progAck(progAck), .anyTermProgrammed(anyTermProgrammed));

`default_nettype wire

// File: tb/fpr_rom_sockets.sv
`timescale 1ns/1ps
`default_nettype none

// rom sockets on the data bus; a count above one would be a bus fight
module fpr_rom_sockets
(
    input wire fpr_pkg::fpr_sel_s sel,
    output logic [3:0] activeCount
);
    // count every chip whose select is low
    always_comb
    begin
        activeCount = 4'(!sel.bankRomEnableN) + 4'(!sel.patchRomEnableN);
        for (int i = 0; i < fpr_pkg::SYS_ROMS; i++)
        begin
            activeCount += 4'(!sel.systemRomEnableN[i]);
        end
    end
endmodule

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam logic [15:0] PROBE [5] = '{16'h6000, 16'h67ff, 16'h6800, 16'h5fff, 16'h6000};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] addrBus = 16'h0000;
    logic bankRomSelect = 1'b0;
    logic progWrite = 1'b0;
    fpr_pkg::fpr_prog_s prog = '0;
    fpr_pkg::fpr_sel_s sel;
    logic progAck;
    logic anyTermProgrammed;
    logic [3:0] activeCount;
    int fail_count = 0;
    int n_compared = 0;

    always #12.5 clk = ~clk;

    fpr_remap uut (.clk(clk), .rst(rst), .addrBus(addrBus), .bankRomSelect(bankRomSelect),
        .progWrite(progWrite), .prog(prog), .sel(sel), .progAck(progAck),
        .anyTermProgrammed(anyTermProgrammed));
    fpr_rom_sockets roms (.sel(sel), .activeCount(activeCount));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // present one address; selects are read after the edge that registers them
    task automatic put(input logic [15:0] a, input logic b);
        @(posedge clk);
        addrBus <= a;
        bankRomSelect <= b;
        @(posedge clk);
        #1;
    endtask

    // one term that matches exactly address a, bits 1:0 ignored
    task automatic write_term(input logic [5:0] t, input logic [15:0] a, input logic [7:0] o);
        @(posedge clk);
        progWrite <= 1'b1;
        prog <= '{t, a[15:2], ~a[15:2], o};
        @(posedge clk);
        progWrite <= 1'b0;
        #1;
        chk("progAck", 16'(32'(t) < fpr_pkg::TERMS), 16'(progAck));
    endtask

    task automatic t_idle;
        logic [15:0] a;
        for (int k = 0; k < 16; k++)
        begin
            a = {1'b1, 4'(k), 11'h5a3};
            put(a, 1'b0);
            chk("decodeN", ~(16'h0001 << k), sel.decodeN);
            chk("patchAddr", 16'(a[10:0]), 16'(sel.patchAddr));
            chk("patchRomEnableN", 16'(k != 0), 16'(sel.patchRomEnableN));
            chk("activeCount", 16'(k == 0 || k > 3), 16'(activeCount));
        end
        put(16'h7fff, 1'b0);
        chk("decodeN", 16'hffff, sel.decodeN);
    endtask

    task automatic t_bank;
        logic b;
        for (int i = 0; i < 5; i++)
        begin
            b = i < 4;
            put(PROBE[i], b);
            chk("bankRomEnableN", 16'(!(b && PROBE[i][15:11] == 5'h0c)), 16'(sel.bankRomEnableN));
            chk("bankAddr", 16'(PROBE[i][10:0]), 16'(sel.bankAddr));
        end
    endtask

    // refused term first, then a correction across one 4-byte block,
    // then one inside the bank window that must silence the bank rom
    task automatic t_patch;
        logic [15:0] a;
        write_term(6'h30, 16'h9abc, 8'hc0);
        put(16'h9abc, 1'b1);
        chk("correctN", 16'h0001, 16'(sel.correctN));
        chk("anyTermProgrammed", 16'h0000, 16'(anyTermProgrammed));
        write_term(6'h2f, 16'h9abc, 8'hd5);
        for (int i = 0; i < 4; i++)
        begin
            a = 16'h9abc + 16'(i);
            put(a, 1'b1);
            chk("correctN", 16'h0000, 16'(sel.correctN));
            chk("patchAddr", {5'h00, 6'h15, !a[2], a[1:0]}, 16'(sel.patchAddr));
            chk("activeCount", 16'h0001, 16'(activeCount));
        end
        chk("anyTermProgrammed", 16'h0001, 16'(anyTermProgrammed));
        put(16'h9ab8, 1'b0);
        chk("patchAddr", 16'h02b8, 16'(sel.patchAddr));
        write_term(6'h00, 16'h6124, 8'h83);
        put(16'h6126, 1'b1);
        chk("patchAddr", 16'h001e, 16'(sel.patchAddr));
        chk("bankRomEnableN", 16'h0001, 16'(sel.bankRomEnableN));
        chk("activeCount", 16'h0001, 16'(activeCount));
    endtask

    task automatic wrap_up;
        if (fail_count == 0 && n_compared > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_idle();
        t_bank();
        t_patch();
        wrap_up();
    end

    // watchdog, far beyond the under one hundred cycles the run needs
    initial
    begin
        #100000;
        fail_count++;
        wrap_up();
    end
endmodule

`default_nettype wire
